// file: spkdiag_pkg.sv
/*
  Package for the speaker load diagnostic sequencer: register map, field
  positions, timing figures in milliseconds with derived sample-tick counts,
  state encodings and the analog sense carrier.
  Assumes a 250 MHz system clock and a 48 kHz sample-rate tick.
*/
`default_nettype none
package spkdiag_pkg;
  // System clock and sample rate
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int FS_HZ = 48_000;
  localparam int FS_DIV = SYS_CLK_HZ / FS_HZ; // Cycles per sample tick

  // Times in ms, as printed
  localparam int T_RAMP_MS = 10;    // Output rise or fall, regulator ramp
  localparam int T_PLAT_MS = 80;    // Short-phase plateau, permanent plateau
  localparam int T_DET_BASE_MS = 86;
  localparam int T_DET_SPAN_MS = 140;
  localparam int T_RESTART_MS = 2;
  localparam int T_RU_MAX_MS = 70;  // Cap on a pulse ramp

  // Derived counts in sample ticks
  localparam logic [15:0] TK_RAMP = 16'(T_RAMP_MS * FS_HZ / 1000);
  localparam logic [15:0] TK_PLAT = 16'(T_PLAT_MS * FS_HZ / 1000);
  localparam logic [15:0] TK_DET_BASE = 16'(T_DET_BASE_MS * FS_HZ / 1000);
  localparam logic [15:0] TK_DET_SPAN = 16'(T_DET_SPAN_MS * FS_HZ / 1000);
  localparam logic [15:0] TK_RESTART = 16'(T_RESTART_MS * FS_HZ / 1000);
  localparam logic [15:0] TK_RU_MAX = 16'(T_RU_MAX_MS * FS_HZ / 1000);

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CH1 = 8'h08;
  localparam logic [7:0] ADDR_CH4 = 8'h14;

  // Control fields
  localparam int CTRL_DIAG_EN = 0;  // diag_enable_bit
  localparam int CTRL_AMP_MODE = 1; // amp_mode_bit
  localparam int CTRL_LDSEL_LO = 2; // line_driver_select_bits [3:2]
  localparam int CTRL_MULT_LO = 5;  // plateau_multiplier_field [7:5]
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hef;

  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 6;    // results_valid_bit

  // Fault byte fields
  localparam int FB_GND = 0;
  localparam int FB_VS = 1;
  localparam int FB_OPEN = 2;
  localparam int FB_LOAD = 3;
  localparam int FB_PERM = 4;

  // Turn-on sequence states
  typedef enum logic [16:0] {
    T_IDLE = 17'h00001, T_SS_RISE = 17'h00002, T_SS_PLAT = 17'h00004,
    T_SS_FALL = 17'h00008, T_HS_REG_UP = 17'h00010, T_HS_RISE = 17'h00020,
    T_HS_PLAT = 17'h00040, T_HS_FALL = 17'h00080, T_HS_REG_DN = 17'h00100,
    T_DT_RISE = 17'h00200, T_DT_UP = 17'h00400, T_DT_PLAT = 17'h00800,
    T_DT_DN = 17'h01000, T_DT_GAP_FALL = 17'h02000, T_DT_GAP_RISE = 17'h04000,
    T_DT_FALL = 17'h08000, T_DONE = 17'h10000
  } ton_state_t;

  // Permanent diagnostic states, one machine per channel
  typedef enum logic [2:0] {
    P_PLAY = 3'h1, P_RESTART = 3'h2, P_PLATEAU = 3'h4
  } perm_state_t;

  // Comparator and over-current levels from the analog side, one bit per channel except the single pulse_limit bit
  typedef struct packed {
    logic [3:0] soft_short;
    logic [3:0] short_gnd;
    logic [3:0] short_vs;
    logic [3:0] short_load;
    logic [3:0] open_load;
    logic [3:0] over_current;
    logic pulse_limit;   // Test current reached during a pulse ramp
  } sense_t;
endpackage
`default_nettype wire

// file: spkdiag_seq.sv
/*
  Speaker load diagnostic sequencer: turn-on diagnostic phase timing,
  per-channel permanent diagnostic, fault bytes on an Avalon-MM slave.
  Assumes the analog sense levels arrive asynchronously and are held by the
  analog side; all timing runs on a sample tick divided from I_CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - Output ramps 10 ms, plus 10 with regulator
// RULE2 - Short-phase plateau 80 ms, never multiplied
// RULE3 - Detection plateau multiplier 1, 2, 4, 8
// RULE4 - Detect plateau 86 ms or span minus ramps
// RULE5 - Pulse is ramp up, plateau, ramp down
// RULE6 - Soft-short phase: rise, plateau, fall, regulator off
// RULE7 - Hard-short phase: regulator ramps, rise, plateau, fall
// RULE8 - Soft first, then hard or detection pulses
// RULE9 - Permanent diagnostic while biased and enabled
// RULE10 - Permanent reports ground, supply, across-load shorts
// RULE11 - Restart cycle is a 2 ms check
// RULE12 - Plateau cycle 80 ms, results stored
// RULE13 - Disabled: restart every 2 ms until clear
// RULE14 - Disabled: no reports, permanent bits cleared
// RULE15 - Enabled: one restart, resume if clear
// RULE16 - Still overloaded: run one plateau cycle
// RULE17 - After plateau, restart every 2 ms
// RULE18 - Plateau completion sets fault bit 4
// RULE19 - Fault read retriggers plateau if overload remains
// RULE20 - Reading channel four clears all bytes
// RULE21 - Start on enable rise with amp mode zero
// RULE22 - Bits: ground 0, supply 1, open 2, load 3
// RULE23 - Status bit 6 marks results valid
// RULE24 - Durations counted in 48 kHz sample ticks
// RULE25 - Independent permanent machine per channel
module spkdiag_seq
  import spkdiag_pkg::*;
#(
  parameter int FS_DIVIDE = FS_DIV
)(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_BIASED,
  input wire sense_t I_SENSE,
  output logic O_OUT_DRIVE,
  output logic O_REG_ENABLE,
  output logic O_PULSE_ACTIVE,
  output logic O_HIGH_CURRENT,
  output logic O_DIAG_BUSY,
  output logic [3:0] O_CH_OFF
);

  // Synchronised sense levels
  sense_t sense_meta; // First stage, read only by the second
  sense_t sense;
  logic biased_meta;
  logic biased;

  // Registers
  logic [7:0] ctrl;
  logic [7:0] fault [4];
  logic valid;
  logic diag_en_d;

  // Bus access
  logic acc;
  logic acc_rd;
  logic clr_all;
  logic [3:0] rd_hit;

  // Sample tick divider
  logic [15:0] div_cnt;
  logic fs_tick;

  // Turn-on sequencer
  ton_state_t ton;
  ton_state_t next_ton;
  logic [15:0] cnt;
  logic [15:0] target;
  logic [15:0] pulse_ramp_time;
  logic [15:0] tp;
  logic [15:0] span;
  logic step;
  logic pulse_two;
  logic [3:0] ss_stab, gnd_stab, vs_stab, ld_stab, op_stab;
  logic ton_done;
  logic ton_start;

  // Per-channel permanent machine outputs
  logic [3:0] ch_off;

  // Two-stage synchronisers for everything from the analog side
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      sense_meta <= '0;
      sense <= '0;
      biased_meta <= 1'b0;
      biased <= 1'b0;
    end
    else
    begin
      sense_meta <= I_SENSE;
      sense <= sense_meta;
      biased_meta <= I_BIASED;
      biased <= biased_meta;
    end
  end

  // Sample tick, one cycle in FS_DIVIDE
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      div_cnt <= 16'h0000;
      fs_tick <= 1'b0;
    end
    else if (div_cnt == 16'(FS_DIVIDE - 1))
    begin
      div_cnt <= 16'h0000;
      fs_tick <= 1'b1; // [RULE24]
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      fs_tick <= 1'b0;
    end
  end

  // Access completes on the edge where waitrequest is seen low
  assign acc = (I_AVS_READ | I_AVS_WRITE) & ~O_AVS_WAITREQUEST;
  assign acc_rd = acc & I_AVS_READ;
  assign clr_all = acc_rd & (I_AVS_ADDRESS == ADDR_CH4); // [RULE20]
  always_comb
  begin
    for (int c = 0; c < 4; c++)
      rd_hit[c] = acc_rd & (I_AVS_ADDRESS == ADDR_CH1 + 8'(4 * c));
  end

  // Waitrequest: one wait cycle per access, read data loaded meanwhile
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h00000000;
    end
    else if ((I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST)
    begin
      O_AVS_WAITREQUEST <= 1'b0;
      case (I_AVS_ADDRESS)
        ADDR_CTRL: O_AVS_READDATA <= {24'h000000, ctrl};
        ADDR_STATUS: O_AVS_READDATA <= {25'h0000000, valid, 5'h00, O_DIAG_BUSY}; // [RULE23]
        ADDR_CH1: O_AVS_READDATA <= {24'h000000, fault[0]};
        ADDR_CH1 + 8'h04: O_AVS_READDATA <= {24'h000000, fault[1]};
        ADDR_CH1 + 8'h08: O_AVS_READDATA <= {24'h000000, fault[2]};
        ADDR_CH4: O_AVS_READDATA <= {24'h000000, fault[3]};
        default: O_AVS_READDATA <= 32'h00000000; // Unmapped reads as zero
      endcase
    end
    else
      O_AVS_WAITREQUEST <= 1'b1;
  end

  // Control register; only byte lane 0 is implemented
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      ctrl <= CTRL_RESET;
    else if (acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0] & (I_AVS_ADDRESS == ADDR_CTRL))
      ctrl <= I_AVS_WRITEDATA[7:0] & CTRL_MASK;
  end

  // Enable edge detect for the turn-on trigger
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      diag_en_d <= 1'b0;
    else
      diag_en_d <= ctrl[CTRL_DIAG_EN];
  end
  assign ton_start = ctrl[CTRL_DIAG_EN] & ~diag_en_d & ~ctrl[CTRL_AMP_MODE]; // [RULE21]

  // Detection plateau from measured ramp and multiplier
  always_comb
  begin
    span = TK_DET_SPAN - {pulse_ramp_time[14:0], 1'b0};
    if (span > TK_PLAT && TK_DET_SPAN > {pulse_ramp_time[14:0], 1'b0})
      tp = TK_DET_BASE; // [RULE4]
    else
      tp = span;
    case (ctrl[CTRL_MULT_LO +: 3])
      3'h0: tp = tp;                   // [RULE3]
      3'h1: tp = {tp[14:0], 1'b0};
      3'h2: tp = {tp[13:0], 2'b00};
      default: tp = {tp[12:0], 3'b000};
    endcase
  end

  // Length of each timed phase in sample ticks
  always_comb
  begin
    case (ton)
      T_SS_PLAT, T_HS_PLAT: target = TK_PLAT;   // [RULE2]
      T_DT_RISE, T_DT_FALL: target = {TK_RAMP[14:0], 1'b0}; // [RULE1]
      T_DT_UP: target = TK_RU_MAX;
      T_DT_PLAT: target = tp;
      T_DT_DN: target = pulse_ramp_time;                    // [RULE5]
      default: target = TK_RAMP;
    endcase
  end
  assign step = fs_tick & (cnt + 16'h0001 >= target);

  // Turn-on phase order
  always_comb
  begin
    next_ton = ton;
    case (ton)
      T_IDLE: if (ton_start) next_ton = T_SS_RISE;
      T_SS_RISE: if (step) next_ton = T_SS_PLAT;   // [RULE6]
      T_SS_PLAT: if (step) next_ton = T_SS_FALL;
      T_SS_FALL:
        if (step)
          next_ton = (|ss_stab) ? T_HS_REG_UP : T_DT_RISE; // [RULE8]
      T_HS_REG_UP: if (step) next_ton = T_HS_RISE;   // [RULE7]
      T_HS_RISE: if (step) next_ton = T_HS_PLAT;
      T_HS_PLAT: if (step) next_ton = T_HS_FALL;
      T_HS_FALL: if (step) next_ton = T_HS_REG_DN;
      T_HS_REG_DN: if (step) next_ton = T_DONE;
      T_DT_RISE: if (step) next_ton = T_DT_UP;
      T_DT_UP:
        if (step || (fs_tick && sense.pulse_limit))
          next_ton = T_DT_PLAT;
      T_DT_PLAT: if (step) next_ton = T_DT_DN;
      T_DT_DN:
        if (step)
        begin
          // Second pulse only when an open load is suspected
          if (!pulse_two && |op_stab) // [RULE8]
            next_ton = (|ctrl[CTRL_LDSEL_LO +: 2]) ? T_DT_GAP_FALL : T_DT_UP;
          else
            next_ton = T_DT_FALL;
        end
      T_DT_GAP_FALL: if (step) next_ton = T_DT_GAP_RISE;
      T_DT_GAP_RISE: if (step) next_ton = T_DT_UP;
      T_DT_FALL: if (step) next_ton = T_DONE;
      T_DONE: next_ton = T_IDLE;
      default: next_ton = T_IDLE;
    endcase
  end

  // State and phase counter
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      ton <= T_IDLE;
      cnt <= 16'h0000;
    end
    else
    begin
      ton <= next_ton;
      if (next_ton != ton)
        cnt <= 16'h0000;
      else if (fs_tick && ton != T_IDLE)
        cnt <= cnt + 16'h0001;
    end
  end

  // Ramp measurement and pulse count
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      pulse_ramp_time <= 16'h0000;
      pulse_two <= 1'b0;
    end
    else
    begin
      if (ton == T_IDLE)
        pulse_two <= 1'b0;
      else if (ton == T_DT_DN && next_ton != T_DT_DN && next_ton != T_DT_FALL)
        pulse_two <= 1'b1;
      // Ramp-up length is what the ramp-down then reuses
      if (ton == T_DT_UP && next_ton == T_DT_PLAT)
        pulse_ramp_time <= cnt + 16'h0001;
    end
  end

  // Comparators must hold through a whole plateau to count
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      ss_stab <= 4'h0;
      gnd_stab <= 4'h0;
      vs_stab <= 4'h0;
      ld_stab <= 4'h0;
      op_stab <= 4'h0;
    end
    else if (fs_tick)
    begin
      if (ton == T_SS_PLAT)
        ss_stab <= (cnt == 16'h0000) ? sense.soft_short : ss_stab & sense.soft_short;
      if (ton == T_HS_PLAT)
      begin
        gnd_stab <= (cnt == 16'h0000) ? sense.short_gnd : gnd_stab & sense.short_gnd;
        vs_stab <= (cnt == 16'h0000) ? sense.short_vs : vs_stab & sense.short_vs;
      end
      if (ton == T_DT_PLAT)
      begin
        if (!pulse_two)
          ld_stab <= (cnt == 16'h0000) ? sense.short_load : ld_stab & sense.short_load;
        op_stab <= (cnt == 16'h0000) ? sense.open_load : op_stab & sense.open_load;
      end
      if (ton == T_SS_RISE)
      begin
        // Stale results from an earlier run must not leak through
        gnd_stab <= 4'h0;
        vs_stab <= 4'h0;
        ld_stab <= 4'h0;
        op_stab <= 4'h0;
      end
    end
  end
  assign ton_done = (ton == T_DONE);

  // Drive outputs of the turn-on sequence
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      O_OUT_DRIVE <= 1'b0;
      O_REG_ENABLE <= 1'b0;
      O_PULSE_ACTIVE <= 1'b0;
      O_HIGH_CURRENT <= 1'b0;
      O_DIAG_BUSY <= 1'b0;
    end
    else
    begin
      O_OUT_DRIVE <= !(next_ton inside {T_IDLE, T_HS_REG_UP, T_HS_REG_DN, T_DONE});
      O_REG_ENABLE <= next_ton inside {T_HS_REG_UP, T_HS_RISE, T_HS_PLAT, T_HS_FALL,
        T_HS_REG_DN, T_DT_RISE, T_DT_UP, T_DT_PLAT, T_DT_DN, T_DT_GAP_FALL,
        T_DT_GAP_RISE, T_DT_FALL}; // [RULE6] [RULE7]
      O_PULSE_ACTIVE <= next_ton inside {T_DT_UP, T_DT_PLAT, T_DT_DN};
      O_HIGH_CURRENT <= (next_ton inside {T_DT_UP, T_DT_PLAT, T_DT_DN}) & ~pulse_two;
      O_DIAG_BUSY <= (next_ton != T_IDLE);
    end
  end

  // Results valid flag; completion wins over a clearing read
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      valid <= 1'b0;
    else if (ton_done)
      valid <= 1'b1; // [RULE23]
    else if (clr_all || ton_start)
      valid <= 1'b0;
  end

  // One independent permanent machine per channel
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    perm_state_t pst;
    logic [15:0] pcnt;
    logic first;
    logic replay;
    logic oc;
    logic [2:0] pstab; // Ground, supply, load
    logic pend;

    assign oc = sense.over_current[g];
    assign pend = fs_tick & (pcnt >= ((pst == P_PLATEAU) ? TK_PLAT : TK_RESTART) - 16'h0001);

    // Channel sequence
    always_ff @(posedge I_CLK_SYS)
    begin
      if (I_RST || !biased)
      begin
        pst <= P_PLAY;
        pcnt <= 16'h0000;
        first <= 1'b0;
        ch_off[g] <= 1'b0;
      end
      else
      begin
        case (pst)
          P_PLAY:
            if (oc)
            begin
              pst <= P_RESTART; // [RULE25]
              first <= 1'b1;
              pcnt <= 16'h0000;
              ch_off[g] <= 1'b1;
            end
          P_RESTART:
            if (pend)
            begin
              pcnt <= 16'h0000;
              first <= 1'b0;
              if (!oc)
              begin
                pst <= P_PLAY; // [RULE15] [RULE13]
                ch_off[g] <= 1'b0;
              end
              else if (ctrl[CTRL_DIAG_EN] && (first || replay))
                pst <= P_PLATEAU; // [RULE16] [RULE9]
            end
            else if (fs_tick)
              pcnt <= pcnt + 16'h0001; // [RULE11]
          P_PLATEAU:
            if (pend)
            begin
              pst <= P_RESTART; // [RULE17]
              pcnt <= 16'h0000;
            end
            else if (fs_tick)
              pcnt <= pcnt + 16'h0001; // [RULE12]
          default: pst <= P_PLAY;
        endcase
      end
    end

    // Replay request taken from a read while restarts run
    always_ff @(posedge I_CLK_SYS)
    begin
      if (I_RST)
        replay <= 1'b0;
      else if (pst != P_RESTART)
        replay <= 1'b0;
      else if (rd_hit[g] && !first && oc)
        replay <= 1'b1; // [RULE19]
    end

    // Stable shorts over the plateau cycle
    always_ff @(posedge I_CLK_SYS)
    begin
      if (I_RST)
        pstab <= 3'h0;
      else if (fs_tick && pst == P_PLATEAU)
      begin
        if (pcnt == 16'h0000)
          pstab <= {sense.short_load[g], sense.short_vs[g], sense.short_gnd[g]}; // [RULE10]
        else
          pstab <= pstab & {sense.short_load[g], sense.short_vs[g], sense.short_gnd[g]};
      end
    end

    // Fault byte; any set in the same cycle wins over the clearing read
    always_ff @(posedge I_CLK_SYS)
    begin
      if (I_RST)
        fault[g] <= 8'h00;
      else
      begin
        if (clr_all)
          fault[g] <= 8'h00; // [RULE20]
        if (ton_done)
        begin
          fault[g][FB_GND] <= gnd_stab[g]; // [RULE22]
          fault[g][FB_VS] <= vs_stab[g];
          fault[g][FB_LOAD] <= ld_stab[g];
          fault[g][FB_OPEN] <= op_stab[g];
        end
        if (pst == P_PLATEAU && pend)
        begin
          fault[g][FB_GND] <= pstab[0];
          fault[g][FB_VS] <= pstab[1];
          fault[g][FB_LOAD] <= pstab[2];
          fault[g][FB_PERM] <= 1'b1; // [RULE18]
        end
        if (pst == P_RESTART && pend && !ctrl[CTRL_DIAG_EN])
        begin
          fault[g][FB_GND] <= 1'b0; // [RULE14]
          fault[g][FB_VS] <= 1'b0;
          fault[g][FB_LOAD] <= 1'b0;
          fault[g][FB_PERM] <= 1'b0;
        end
      end
    end
  end

  assign O_CH_OFF = ch_off;

endmodule // spkdiag_seq
`default_nettype wire

// file: spkdiag_seq_props.sv
/*
  Checker for the diagnostic sequencer: bus handshake, turn-on start and
  phase timing, permanent restart timing.
  Assumes the ports of spkdiag_seq and a single system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module spkdiag_seq_props
  import spkdiag_pkg::*;
#(
  parameter int FS_DIVIDE = FS_DIV
)(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_BIASED,
  input wire logic O_REG_ENABLE,
  input wire logic O_DIAG_BUSY,
  input wire logic [3:0] O_CH_OFF
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // Slack of a few ticks for phase boundaries
  localparam int SS_CYC = (4800 - 10) * FS_DIVIDE;
  localparam int RS_CYC = (96 - 2) * FS_DIVIDE;
  logic [31:0] busy_cnt; // Cycles busy so far
  logic [31:0] off_cnt [4]; // Cycles each channel has been off
  logic en_shadow; // Last written enable bit
  logic [3:0] early; // Channel came back before a restart ended
  logic ctrl_done; // Control write completes this cycle
  assign ctrl_done = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == ADDR_CTRL
                     && I_AVS_BYTEENABLE[0];
  // Busy length counter
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST) busy_cnt <= 32'h0;
    else busy_cnt <= O_DIAG_BUSY ? busy_cnt + 32'h1 : 32'h0;
  end
  // Per-channel off time
  always_ff @(posedge I_CLK_SYS)
  begin
    for (int k = 0; k < 4; k++)
      off_cnt[k] <= (I_RST || !O_CH_OFF[k]) ? 32'h0 : off_cnt[k] + 32'h1;
  end
  // Enable shadow, so only a rising edge counts as a start
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST) en_shadow <= 1'b0;
    else if (ctrl_done) en_shadow <= I_AVS_WRITEDATA[CTRL_DIAG_EN];
  end
  // Early return is flagged without sampled-value functions
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      early[k] = !O_CH_OFF[k] && off_cnt[k] != 32'h0 && off_cnt[k] < 32'(RS_CYC);
  end
  property p_wait_answer;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");
  property p_wait_one;
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_start;
    ctrl_done && I_AVS_WRITEDATA[CTRL_DIAG_EN] && !I_AVS_WRITEDATA[CTRL_AMP_MODE]
      && !en_shadow && !O_DIAG_BUSY |-> ##[1:4] O_DIAG_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("turn-on did not start");
  property p_ss_first;
    $rose(O_DIAG_BUSY) |-> !O_REG_ENABLE [*8];
  endproperty
  a_ss_first: assert property (p_ss_first) else $error("regulator on in soft phase");
  property p_reg_in_diag;
    O_REG_ENABLE |-> O_DIAG_BUSY;
  endproperty
  a_reg_in_diag: assert property (p_reg_in_diag) else $error("regulator outside diag");
  property p_ss_length;
    $fell(O_DIAG_BUSY) |-> busy_cnt >= 32'(SS_CYC);
  endproperty
  a_ss_length: assert property (p_ss_length) else $error("turn-on too short");
  property p_restart_min;
    early == 4'h0;
  endproperty
  a_restart_min: assert property (p_restart_min) else $error("restart too short");
  property p_bias_play;
    !I_BIASED [*4] |=> O_CH_OFF == 4'h0;
  endproperty
  a_bias_play: assert property (p_bias_play) else $error("channel off while unbiased");
  c_done: cover property ($fell(O_DIAG_BUSY));
  c_off: cover property ($rose(O_CH_OFF[1]));
  c_ctrl: cover property (ctrl_done);
endmodule // spkdiag_seq_props
bind spkdiag_seq spkdiag_seq_props #(.FS_DIVIDE(FS_DIVIDE)) i_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_BIASED(I_BIASED), .O_REG_ENABLE(O_REG_ENABLE), .O_DIAG_BUSY(O_DIAG_BUSY),
  .O_CH_OFF(O_CH_OFF)
);
`default_nettype wire

// file: diag_host_model.sv
/*
  Host model: Avalon-MM master that writes the control register and reads the fault bytes.
  Assumes tasks are called right after a rising edge of i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_host_model
  import spkdiag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [7:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  // Idle bus at time zero
  initial
  begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'hf;
  end
  // One access; held until waitrequest is seen low
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        input int gap, output logic [31:0] rdata);
    repeat (gap + 1) @(posedge i_clk);
    o_address <= addr;
    o_read <= !wr;
    o_write <= wr;
    o_writedata <= data;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_clk);
    rdata = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released lines do not keep the last value
    o_address <= ~addr;
    o_writedata <= ~data;
  endtask
  // Channel bytes in order, fourth last since it clears all four
  task automatic read_faults();
    logic [31:0] d;
    for (int ch = 0; ch < 4; ch++)
      access(1'b0, ADDR_CH1 + 8'(4 * ch), 32'h0, 0, d);
  endtask
endmodule // diag_host_model
`default_nettype wire

// file: speaker_diagnostic_sequencer_test.sv
/*
  Testbench: turn-on hard-short path, register access, permanent restart
  and plateau cycles, enable-off restart mode.
  Assumes the host model drives the bus; expectations go through a queue.
*/
`timescale 1ns/1ps
`default_nettype none
module speaker_diagnostic_sequencer_test;
  import spkdiag_pkg::*;
  localparam int FSD = 3; // Short tick keeps the run brief
  localparam int TOL = 40 * FSD; // Slack for phase boundaries
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic biased = 1'b0;
  sense_t sense = '0;
  logic [7:0] address;
  logic read, write, waitrequest;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, ch_off;
  logic out_drive, reg_enable, diag_busy, pulse_active;
  int n_fail = 0;
  int check_count = 0;
  int seed = 76048;
  int busy_n = 0, reg_n = 0, drive_n = 0, off_n = 0, pulse_n = 0; // High-time counters
  logic [31:0] exp_q [$]; // Expected read data, oldest first
  always #2 clk_sys = ~clk_sys;
  spkdiag_seq #(.FS_DIVIDE(FSD)) i_dut (
    .I_CLK_SYS(clk_sys), .I_RST(rst), .I_AVS_ADDRESS(address), .I_AVS_READ(read),
    .I_AVS_WRITE(write), .I_AVS_WRITEDATA(writedata), .I_AVS_BYTEENABLE(byteenable),
    .O_AVS_READDATA(readdata), .O_AVS_WAITREQUEST(waitrequest), .I_BIASED(biased),
    .I_SENSE(sense), .O_OUT_DRIVE(out_drive), .O_REG_ENABLE(reg_enable),
    .O_PULSE_ACTIVE(pulse_active), .O_HIGH_CURRENT(), .O_DIAG_BUSY(diag_busy), .O_CH_OFF(ch_off)
  );
  diag_host_model i_host (
    .i_clk(clk_sys), .i_waitrequest(waitrequest), .i_readdata(readdata),
    .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
    .o_byteenable(byteenable)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Duration within slack; a miss prints the measured value
  task automatic near(input int got, input int exp);
    check((got > exp - TOL && got < exp + TOL) ? 32'(exp) : 32'(got), 32'(exp));
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    exp_q.push_back(exp);
    i_host.access(1'b0, addr, 32'h0, $random(seed) & 3, d);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    i_host.access(1'b1, addr, data, $random(seed) & 3, d);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Output monitor: read data against oldest note
  always @(posedge clk_sys)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
      check(readdata, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffffffff);
  end
  // High-time counters for phase lengths
  always @(posedge clk_sys)
  begin
    busy_n += (diag_busy === 1'b1);
    reg_n += (reg_enable === 1'b1);
    drive_n += (out_drive === 1'b1);
    off_n += (ch_off[2] === 1'b1);
    pulse_n += (pulse_active === 1'b1);
  end
  // Watchdog
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    logic [2:0] mult;
    int k;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    biased <= 1'b1;
    sense.soft_short <= 4'h1;
    sense.short_gnd <= 4'h1;
    mult = 3'($random(seed));
    // Enable only, amp mode stays zero; bit 4 is written but reads zero
    wr(ADDR_CTRL, {24'($random(seed)), mult, 5'b10001});
    rd(ADDR_CTRL, {24'h0, mult, 5'b00001});
    rd(8'h40, 32'h0);
    for (k = 0; k < 60000 && !(busy_n > 0 && diag_busy === 1'b0); k++) @(posedge clk_sys);
    near(busy_n, 10560 * FSD);
    near(reg_n, 5760 * FSD);
    near(drive_n, 9600 * FSD);
    sense <= '0;
    rd(ADDR_STATUS, 32'h40);
    for (k = 0; k < 4; k++) exp_q.push_back((k == 0) ? 32'h1 : 32'h0);
    i_host.read_faults();
    rd(ADDR_CH1, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    // Brief overload on channel 3: one restart, then play
    sense.over_current <= 4'h4;
    repeat (20 * FSD) @(posedge clk_sys);
    sense.over_current <= 4'h0;
    repeat (150 * FSD) @(posedge clk_sys);
    near(off_n, 96 * FSD);
    check(32'(ch_off), 32'h0);
    rd(ADDR_CH1 + 8'h08, 32'h0);
    // Lasting overload on channel 2: plateau, then restart loop
    sense.over_current <= 4'h2;
    sense.short_load <= 4'h2;
    repeat (20 * FSD) @(posedge clk_sys);
    check(32'(ch_off), 32'h2);
    repeat ((96 + 3840 + 40) * FSD) @(posedge clk_sys);
    check(32'(ch_off), 32'h2);
    rd(ADDR_CH1 + 8'h04, 32'h18);
    wr(ADDR_CTRL, 32'h0);
    repeat (200 * FSD) @(posedge clk_sys);
    rd(ADDR_CH1 + 8'h04, 32'h0);
    check(32'(ch_off), 32'h2);
    sense <= '0;
    repeat (150 * FSD) @(posedge clk_sys);
    check(32'(ch_off), 32'h0);
    // No soft short: one detection pulse, x1
    sense.pulse_limit <= 1'b1;
    busy_n = 0;
    wr(ADDR_CTRL, 32'h1);
    for (k = 0; k < 60000 && !(busy_n > 0 && diag_busy === 1'b0); k++) @(posedge clk_sys);
    near(busy_n, 10850 * FSD);
    near(pulse_n, 4130 * FSD);
    end_of_test();
  end
endmodule // speaker_diagnostic_sequencer_test
`default_nettype wire
